// ==== hw/can_io_cfg.svh ====
`ifndef CAN_IO_CFG_SVH
`define CAN_IO_CFG_SVH
// ---------------------------------------------
// Expansion map
// ---------------------------------------------
`define EXP_BASE_DEFAULT 8'h20
`define CHAN_BASE 9'h020
`define MOD_MAX 16
`define MOD_CHANS 16
`define BUILTIN_INS 20
`define MIRROR_LO 9'h014
`define MIRROR_COUNT 12
`define AXIS_SEL_MAX 9'h01f
`define POS_OUT_LO 9'h008
`define POS_OUT_HI 9'h011
`define FAST_TIER_HI 9'h04f
`define SLOW_TIER_HI 9'h0cf
`define CHAN_LAST 9'h11f
// ---------------------------------------------
// Timing
// ---------------------------------------------
`define CLK_PERIOD_NS 8
`define SLOT_TIME_NS 125000
`define SLOT_CYCLES (`SLOT_TIME_NS / `CLK_PERIOD_NS)
`define CAN_BIT_TIME_NS 2000
`define CAN_BIT_CYCLES (`CAN_BIT_TIME_NS / `CLK_PERIOD_NS)
`define FAST_MODS 2'h3
`define SLOW_FIRST 4'h3
`define SLOW_LAST 4'hf
`define MISS_LIMIT 2'h3
`define FAULT_NONE 4'h0
`endif

// ==== hw/can_io_expansion_map.sv ====
// Functional notes
// - Two CAN channels; first reserved for expansion
// - Expansion runs only when base equals 32
// - Sixteen channels per module, input or output
// - At most sixteen modules, 256 channels
// - All nodes signal at 500kHz
// - Address N maps to 32+16N..47+16N
// - Built-in inputs are numbers 0..19
// - First 12 module inputs mirrored at 20..31
// - Detect modules, report total channel count
// - Axis inputs selectable only up to 31
// - Position output command only outputs 8..17
// - Refresh below 1, 2, 8 ms by tier; tiers 2 and 3 are both polled every 6.5 ms
// - Bad configuration gives wrong channel count
`timescale 1ns/1ps
`include "can_io_cfg.svh"
module can_io_expansion_map import can_io_pkg::*; #(
    parameter int SLOT_CYCLES = `SLOT_CYCLES
) (
    input wire logic mclk, // System clock
    input wire logic reset, // Sync reset
    input wire logic [7:0] expansionBaseParam, // Expansion base address
    input wire logic expansionAllowParam, // Software enable
    input wire logic [19:0] builtinIn, // Local input pins
    input rsp_s rsp, // Answer from channel A
    input wire logic outWe, // Output write strobe
    input wire logic [8:0] outChan, // Output channel number
    input wire logic outVal, // Output level
    input wire logic [8:0] rdChan, // Input channel to read
    input wire logic [8:0] axisSel, // Axis input number
    input wire logic posCmd, // Position output strobe
    input wire logic [8:0] posChan, // Position output number
    input wire logic posVal, // Position output level
    output poll_s poll_ff, // Poll to channel A
    output logic chanAExpansion_ff, // Channel A owned
    output logic chanBFree_ff, // Channel B for other protocols
    output logic [7:0] bitPrescale_ff, // Cycles per CAN bit less one
    output exp_state_e expansionStateParam_ff, // Expansion state
    output logic [8:0] channelCountParam_ff, // Channels present
    output logic configFault_ff, // Network misconfigured
    output logic rdVal_ff, // Read channel level
    output logic [1:0] rdTier_ff, // Refresh tier of read channel
    output logic axisVal_ff, // Selected axis input level
    output logic axisSelBad_ff, // Axis number above 31
    output logic posReject_ff, // Position command refused
    output logic [31:0] localOut_ff // Built-in outputs
);
    // ---------------------------------------------
    // Channel decode
    // ---------------------------------------------
    function automatic logic isExp(input logic [8:0] ch);
        return (ch >= `CHAN_BASE) && (ch <= `CHAN_LAST);
    endfunction

    function automatic logic [3:0] modOf(input logic [8:0] ch);
        logic [8:0] off;
        off = ch - `CHAN_BASE;
        return off[7:4];
    endfunction

    // ---------------------------------------------
    // Enable and link setup
    // ---------------------------------------------
    logic run;
    logic slotTick;
    logic [3:0] slotAddr;
    logic [4:0] modCount;
    logic [8:0] chanCount;
    logic gap;

    assign run = expansionAllowParam && (expansionBaseParam == `EXP_BASE_DEFAULT);

    always_ff @(posedge mclk) begin
        if (reset) begin
            chanAExpansion_ff <= 1'b0;
            chanBFree_ff <= 1'b1;
            bitPrescale_ff <= 8'h0;
        end else begin
            chanAExpansion_ff <= run;
            chanBFree_ff <= 1'b1;
            bitPrescale_ff <= 8'(`CAN_BIT_CYCLES - 1);
        end
    end

    poll_sched #(
        .SLOT_CYCLES(SLOT_CYCLES)
    ) u_sched (
        .mclk(mclk),
        .reset(reset),
        .run(run),
        .slotTick_ff(slotTick),
        .slotAddr_ff(slotAddr)
    );

    // ---------------------------------------------
    // Module tables
    // ---------------------------------------------
    logic [15:0] inTable [16];
    logic [15:0] outTable [16];
    logic [15:0] present_ff;
    logic [15:0] faulted_ff;
    logic [1:0] miss_ff [16];
    logic waiting_ff;
    logic [3:0] waitAddr_ff;
    logic rspHit;

    // Answers outside the polled slot are stale and dropped
    assign rspHit = rsp.valid && waiting_ff && (rsp.addr == {2'h0, waitAddr_ff});

    always_ff @(posedge mclk) begin
        if (reset || !run) begin
            poll_ff <= '0;
            waiting_ff <= 1'b0;
            waitAddr_ff <= 4'h0;
        end else begin
            poll_ff.valid <= slotTick;
            if (slotTick) begin
                poll_ff.addr <= slotAddr;
                poll_ff.outData <= outTable[slotAddr];
                waiting_ff <= 1'b1;
                waitAddr_ff <= slotAddr;
            end else if (rspHit) begin
                waiting_ff <= 1'b0;
            end
        end
    end

    // A silent module is dropped only after several missed polls; a faulted answer drops it at once
    always_ff @(posedge mclk) begin
        if (reset || !run) begin
            present_ff <= 16'h0;
            faulted_ff <= 16'h0;
            for (int i = 0; i < `MOD_MAX; i++) begin
                miss_ff[i] <= 2'h0;
            end
        end else if (rspHit) begin
            miss_ff[waitAddr_ff] <= 2'h0;
            present_ff[waitAddr_ff] <= (rsp.fault == `FAULT_NONE);
            faulted_ff[waitAddr_ff] <= (rsp.fault != `FAULT_NONE);
        end else if (slotTick && waiting_ff) begin
            if (miss_ff[waitAddr_ff] == `MISS_LIMIT) begin
                present_ff[waitAddr_ff] <= 1'b0;
            end else begin
                miss_ff[waitAddr_ff] <= miss_ff[waitAddr_ff] + 2'h1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            for (int i = 0; i < `MOD_MAX; i++) begin
                inTable[i] <= 16'h0;
            end
        end else if (rspHit && rsp.fault == `FAULT_NONE) begin
            inTable[waitAddr_ff] <= rsp.inputs;
        end
    end

    // ---------------------------------------------
    // Output writes
    // ---------------------------------------------
    logic posOk;

    assign posOk = (posChan >= `POS_OUT_LO) && (posChan <= `POS_OUT_HI);

    always_ff @(posedge mclk) begin
        if (reset) begin
            for (int i = 0; i < `MOD_MAX; i++) begin
                outTable[i] <= 16'h0;
            end
        end else if (outWe && isExp(outChan)) begin
            outTable[modOf(outChan)][outChan[3:0]] <= outVal;
        end
    end

    // Position command beats a plain write to the same bit
    always_ff @(posedge mclk) begin
        if (reset) begin
            localOut_ff <= 32'h0;
            posReject_ff <= 1'b0;
        end else begin
            if (outWe && outChan < `CHAN_BASE) begin
                localOut_ff[outChan[4:0]] <= outVal;
            end
            if (posCmd && posOk) begin
                localOut_ff[posChan[4:0]] <= posVal;
            end
            posReject_ff <= posCmd && !posOk;
        end
    end

    // ---------------------------------------------
    // Detection and status
    // ---------------------------------------------
    chan_counter u_count (
        .mclk(mclk),
        .reset(reset),
        .present(present_ff),
        .modCount_ff(modCount),
        .chanCount_ff(chanCount),
        .gap_ff(gap)
    );

    always_ff @(posedge mclk) begin
        if (reset) begin
            channelCountParam_ff <= `CHAN_BASE;
            configFault_ff <= 1'b0;
            expansionStateParam_ff <= EXP_OFF;
        end else begin
            channelCountParam_ff <= chanCount;
            configFault_ff <= run && (gap || faulted_ff != 16'h0);
            case (expansionStateParam_ff)
                EXP_OFF: begin
                    if (run) begin
                        expansionStateParam_ff <= EXP_SCAN;
                    end
                end
                EXP_SCAN: begin
                    if (!run) begin
                        expansionStateParam_ff <= EXP_OFF;
                    end else if (configFault_ff) begin
                        expansionStateParam_ff <= EXP_FAULT;
                    end else if (modCount != 5'h0) begin
                        expansionStateParam_ff <= EXP_RUN;
                    end
                end
                EXP_RUN: begin
                    if (!run) begin
                        expansionStateParam_ff <= EXP_OFF;
                    end else if (configFault_ff) begin
                        expansionStateParam_ff <= EXP_FAULT;
                    end else if (modCount == 5'h0) begin
                        expansionStateParam_ff <= EXP_SCAN;
                    end
                end
                EXP_FAULT: begin
                    if (!run) begin
                        expansionStateParam_ff <= EXP_OFF;
                    end else if (!configFault_ff) begin
                        expansionStateParam_ff <= EXP_SCAN;
                    end
                end
                default: begin
                    expansionStateParam_ff <= EXP_OFF;
                end
            endcase
        end
    end

    // ---------------------------------------------
    // Input view
    // ---------------------------------------------
    logic [31:0] lowIn;
    logic [3:0] rdMod;
    logic rdOn;

    // Mirror only counts once module 0 is really there
    always_comb begin
        lowIn = {12'h0, builtinIn};
        if (modCount != 5'h0) begin
            lowIn[31:`BUILTIN_INS] = inTable[0][`MIRROR_COUNT-1:0];
        end
    end

    assign rdMod = modOf(rdChan);
    assign rdOn = isExp(rdChan) && present_ff[rdMod] && ({1'b0, rdMod} < modCount);

    always_ff @(posedge mclk) begin
        if (reset) begin
            rdVal_ff <= 1'b0;
            rdTier_ff <= 2'h3;
        end else begin
            if (rdChan < `CHAN_BASE) begin
                rdVal_ff <= lowIn[rdChan[4:0]];
            end else begin
                rdVal_ff <= rdOn && inTable[rdMod][rdChan[3:0]];
            end
            if (rdChan < `CHAN_BASE) begin
                rdTier_ff <= 2'h0;
            end else if (rdChan <= `FAST_TIER_HI) begin
                rdTier_ff <= 2'h1;
            end else if (rdChan <= `SLOW_TIER_HI) begin
                rdTier_ff <= 2'h2;
            end else begin
                rdTier_ff <= 2'h3;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            axisVal_ff <= 1'b0;
            axisSelBad_ff <= 1'b0;
        end else begin
            axisSelBad_ff <= axisSel > `AXIS_SEL_MAX;
            axisVal_ff <= (axisSel <= `AXIS_SEL_MAX) && lowIn[axisSel[4:0]];
        end
    end
endmodule

// ==== hw/can_io_pkg.sv ====
package can_io_pkg;
    typedef enum logic [1:0] {
        EXP_OFF = 2'b00,
        EXP_SCAN = 2'b01,
        EXP_RUN = 2'b11,
        EXP_FAULT = 2'b10
    } exp_state_e;

    typedef struct packed {
        logic valid;
        logic [3:0] addr;
        logic [15:0] outData;
    } poll_s;

    typedef struct packed {
        logic valid;
        logic [5:0] addr;
        logic [15:0] inputs;
        logic [3:0] fault;
    } rsp_s;
endpackage

// ==== hw/chan_counter.sv ====
`timescale 1ns/1ps
`include "can_io_cfg.svh"
module chan_counter import can_io_pkg::*; (
    input wire logic mclk, // System clock
    input wire logic reset, // Sync reset
    input wire logic [15:0] present, // Module answered
    output logic [4:0] modCount_ff, // Contiguous modules
    output logic [8:0] chanCount_ff, // Total channels
    output logic gap_ff // Module beyond a hole
);
    function automatic logic [4:0] runLen(input logic [15:0] p);
        logic [4:0] n;
        logic stop;
        n = 5'h0;
        stop = 1'b0;
        for (int i = 0; i < `MOD_MAX; i++) begin
            if (!p[i]) begin
                stop = 1'b1;
            end else if (!stop) begin
                n = n + 5'h1;
            end
        end
        return n;
    endfunction

    logic [4:0] n;
    assign n = runLen(present);

    always_ff @(posedge mclk) begin
        if (reset) begin
            modCount_ff <= 5'h0;
            chanCount_ff <= `CHAN_BASE;
            gap_ff <= 1'b0;
        end else begin
            modCount_ff <= n;
            chanCount_ff <= `CHAN_BASE + {n, 4'h0};
            gap_ff <= (present >> n) != 16'h0;
        end
    end
endmodule

// ==== hw/poll_sched.sv ====
`timescale 1ns/1ps
`include "can_io_cfg.svh"
module poll_sched import can_io_pkg::*; #(
    parameter int SLOT_CYCLES = `SLOT_CYCLES
) (
    input wire logic mclk, // System clock
    input wire logic reset, // Sync reset
    input wire logic run, // Expansion active
    output logic slotTick_ff, // Slot start pulse
    output logic [3:0] slotAddr_ff // Module to poll
);
    logic [31:0] timer_ff;
    logic [1:0] phase_ff;
    logic [3:0] slowAddr_ff;
    logic tick;

    assign tick = run && (timer_ff == 32'(SLOT_CYCLES - 1));

    always_ff @(posedge mclk) begin
        if (reset || !run || tick) begin
            timer_ff <= 32'h0;
        end else begin
            timer_ff <= timer_ff + 32'h1;
        end
    end

    // -----------------------------------------
    // Three fast slots then one rotating slot
    // -----------------------------------------
    always_ff @(posedge mclk) begin
        if (reset || !run) begin
            phase_ff <= 2'h0;
            slowAddr_ff <= `SLOW_FIRST;
            slotTick_ff <= 1'b0;
            slotAddr_ff <= 4'h0;
        end else begin
            slotTick_ff <= tick;
            if (tick) begin
                if (phase_ff == `FAST_MODS) begin
                    slotAddr_ff <= slowAddr_ff;
                    slowAddr_ff <= (slowAddr_ff == `SLOW_LAST) ? `SLOW_FIRST
                                   : slowAddr_ff + 4'h1;
                end else begin
                    slotAddr_ff <= {2'h0, phase_ff};
                end
                phase_ff <= phase_ff + 2'h1;
            end
        end
    end
endmodule

// ==== tb/can_io_expansion_map_checker.sv ====
`timescale 1ns/1ps
module can_io_expansion_map_checker import can_io_pkg::*; (
    input wire logic mclk, // Clock
    input wire logic reset, // Sync reset
    input wire logic [7:0] expansionBaseParam, // Base
    input wire logic expansionAllowParam, // Enable
    input wire logic [8:0] rdChan, // Read number
    input wire logic [8:0] axisSel, // Axis number
    input wire logic posCmd, // Pos strobe
    input wire logic [8:0] posChan, // Pos number
    input poll_s poll_ff, // Poll out
    input wire logic chanAExpansion_ff, // A owned
    input wire logic chanBFree_ff, // B free
    input wire logic [7:0] bitPrescale_ff, // Bit divider
    input wire logic [8:0] channelCountParam_ff, // Count
    input wire logic [1:0] rdTier_ff, // Tier
    input wire logic axisSelBad_ff, // Axis refused
    input wire logic posReject_ff // Pos refused
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    function automatic logic [1:0] tierOf(input logic [8:0] ch);
        if (ch < 9'h020) return 2'h0;
        if (ch <= 9'h04f) return 2'h1;
        if (ch <= 9'h0cf) return 2'h2;
        return 2'h3;
    endfunction
    // ---------------------------------------------
    // Port relations
    // ---------------------------------------------
    chk_chan_b_free: assert property (chanBFree_ff)
        else $error("channel B claimed");
    chk_run_gate: assert property (!$past(reset) |-> chanAExpansion_ff ==
        $past(expansionAllowParam && expansionBaseParam == 8'h20))
        else $error("channel A ownership wrong");
    // Margin of three cycles for a tick already in flight
    chk_poll_idle: assert property (!chanAExpansion_ff [*3] |=> !poll_ff.valid)
        else $error("poll while expansion off");
    chk_rate_fix: assert property (!$past(reset) |-> bitPrescale_ff == 8'hf9)
        else $error("bit divider not 500kHz");
    chk_count_step: assert property (channelCountParam_ff[3:0] == 4'h0 &&
        channelCountParam_ff >= 9'h020 && channelCountParam_ff <= 9'h120)
        else $error("channel count off grid");
    chk_tier_map: assert property (!$past(reset) |-> rdTier_ff == tierOf($past(rdChan)))
        else $error("refresh tier wrong");
    chk_axis_range: assert property (!$past(reset) |->
        axisSelBad_ff == ($past(axisSel) > 9'h01f))
        else $error("axis range flag wrong");
    chk_pos_refuse: assert property (!$past(reset) |-> posReject_ff ==
        $past(posCmd && (posChan < 9'h008 || posChan > 9'h011)))
        else $error("position refusal wrong");
endmodule

bind can_io_expansion_map can_io_expansion_map_checker i_chk (.mclk(mclk), .reset(reset),
    .expansionBaseParam(expansionBaseParam), .expansionAllowParam(expansionAllowParam),
    .rdChan(rdChan), .axisSel(axisSel), .posCmd(posCmd), .posChan(posChan),
    .poll_ff(poll_ff), .chanAExpansion_ff(chanAExpansion_ff), .chanBFree_ff(chanBFree_ff),
    .bitPrescale_ff(bitPrescale_ff), .channelCountParam_ff(channelCountParam_ff),
    .rdTier_ff(rdTier_ff), .axisSelBad_ff(axisSelBad_ff), .posReject_ff(posReject_ff));

// ==== tb/can_io_expansion_map_tb_top.sv ====
`timescale 1ns/1ps
module can_io_expansion_map_tb_top import can_io_pkg::*; ;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] expansionBaseParam = 8'h20;
    logic expansionAllowParam = 1'b0;
    logic [19:0] builtinIn = 20'h00000;
    logic outWe = 1'b0;
    logic outVal = 1'b0;
    logic posCmd = 1'b0;
    logic posVal = 1'b0;
    logic [8:0] outChan = 9'h000;
    logic [8:0] rdChan = 9'h000;
    logic [8:0] axisSel = 9'h000;
    logic [8:0] posChan = 9'h000;
    logic [15:0] fitted = 16'h0000;
    logic [255:0] modIn = '0;
    logic [3:0] faultCode = 4'h0;
    logic [3:0] faultAddr = 4'h1;
    logic [3:0] lag = 4'h2;
    rsp_s rsp;
    poll_s poll_ff;
    exp_state_e expansionStateParam_ff;
    logic chanAExpansion_ff, chanBFree_ff, configFault_ff, rdVal_ff, axisVal_ff;
    logic axisSelBad_ff, posReject_ff;
    logic [7:0] bitPrescale_ff;
    logic [8:0] channelCountParam_ff;
    logic [1:0] rdTier_ff;
    logic [31:0] localOut_ff, lo;
    logic [15:0] md;
    int err_total = 0, tests_run = 0, cyc = 0, mods = 0;
    logic [8:0] corner [11] = '{9'h000, 9'h013, 9'h014, 9'h01f, 9'h020, 9'h02f, 9'h04f,
        9'h050, 9'h0cf, 9'h0d0, 9'h11f};
    logic [15:0] fits [3] = '{16'h0007, 16'hffff, 16'h000b};
    int cnts [3] = '{3, 16, 2};

    // Short slots keep a full sixteen-module scan affordable
    can_io_expansion_map #(.SLOT_CYCLES(20)) i_dut (.mclk(mclk), .reset(reset),
        .expansionBaseParam(expansionBaseParam), .expansionAllowParam(expansionAllowParam),
        .builtinIn(builtinIn), .rsp(rsp), .outWe(outWe), .outChan(outChan), .outVal(outVal),
        .rdChan(rdChan), .axisSel(axisSel), .posCmd(posCmd), .posChan(posChan),
        .posVal(posVal), .poll_ff(poll_ff), .chanAExpansion_ff(chanAExpansion_ff),
        .chanBFree_ff(chanBFree_ff), .bitPrescale_ff(bitPrescale_ff),
        .expansionStateParam_ff(expansionStateParam_ff),
        .channelCountParam_ff(channelCountParam_ff), .configFault_ff(configFault_ff),
        .rdVal_ff(rdVal_ff), .rdTier_ff(rdTier_ff), .axisVal_ff(axisVal_ff),
        .axisSelBad_ff(axisSelBad_ff), .posReject_ff(posReject_ff), .localOut_ff(localOut_ff));
    can_io_module_model i_mods (.mclk(mclk), .poll(poll_ff), .fitted(fitted), .modIn(modIn),
        .faultCode(faultCode), .faultAddr(faultAddr), .lag(lag), .rsp(rsp));

    always #4 mclk = ~mclk;
    // ---------------------------------------------
    // Helpers
    // ---------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    function automatic logic expRd(input logic [8:0] ch);
        if (ch < 9'h014) return builtinIn[ch];
        if (ch < 9'h020) return (mods > 0) ? modIn[ch - 9'h014] : 1'b0;
        return (int'((ch - 9'h020) >> 4) < mods) ? modIn[ch - 9'h020] : 1'b0;
    endfunction
    function automatic logic [1:0] expTier(input logic [8:0] ch);
        return ch < 9'h020 ? 2'h0 : ch <= 9'h04f ? 2'h1 : ch <= 9'h0cf ? 2'h2 : 2'h3;
    endfunction
    // Restarting clears presence, so each layout starts clean
    task automatic bringUp(input logic [15:0] fit, input int n, input int settle);
        expansionAllowParam = 1'b0;
        step(4);
        fitted = fit;
        mods = n;
        lag = 4'($urandom_range(12));
        expansionAllowParam = 1'b1;
        step(settle);
    endtask
    task automatic sweep();
        logic [8:0] ch;
        for (int i = 0; i < 40; i++) begin
            ch = i < 11 ? corner[i] : 9'($urandom_range(287));
            rdChan = ch;
            axisSel = ch;
            step(2);
            chk("rdVal", rdVal_ff, expRd(ch));
            chk("rdTier", rdTier_ff, expTier(ch));
            chk("axisBad", axisSelBad_ff, ch > 9'h01f);
            chk("axisVal", axisVal_ff, ch > 9'h01f ? 1'b0 : expRd(ch));
        end
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            err_total = err_total + 1;
            wrap_up();
        end
    end
    // ---------------------------------------------
    // Scenarios
    // ---------------------------------------------
    initial begin
        void'($urandom(32'h4a4e6085));
        for (int i = 0; i < 8; i++) modIn[i*32 +: 32] = $urandom;
        builtinIn = 20'($urandom);
        step(16);
        chk("chanB", chanBFree_ff, 1'b1);
        chk("count", channelCountParam_ff, 9'h020);
        chk("tier", rdTier_ff, 2'h3);
        chk("state", expansionStateParam_ff, EXP_OFF);
        reset = 1'b0;
        done("reset");
        expansionBaseParam = 8'h21 + 8'($urandom_range(200));
        bringUp(16'h0007, 0, 300);
        chk("chanA", chanAExpansion_ff, 1'b0);
        chk("count", channelCountParam_ff, 9'h020);
        chk("state", expansionStateParam_ff, EXP_OFF);
        chk("prescale", bitPrescale_ff, 8'hf9);
        expansionBaseParam = 8'h20;
        done("base");
        for (int t = 0; t < 3; t++) begin
            bringUp(fits[t], cnts[t], t == 0 ? 300 : 1300);
            chk("chanA", chanAExpansion_ff, 1'b1);
            chk("count", channelCountParam_ff, 9'h020 + 9'(cnts[t] * 16));
            chk("fault", configFault_ff, t == 2);
            chk("state", expansionStateParam_ff, t == 2 ? EXP_FAULT : EXP_RUN);
            sweep();
            done("map");
        end
        faultCode = 4'($urandom_range(11, 1));
        bringUp(16'h0003, 1, 300);
        chk("count", channelCountParam_ff, 9'h030);
        chk("fault", configFault_ff, 1'b1);
        chk("state", expansionStateParam_ff, EXP_FAULT);
        sweep();
        done("fault");
        outWe = 1'b1;
        for (int i = 0; i < 48; i++) begin
            outChan = 9'(i);
            outVal = 1'($urandom);
            if (i < 32) lo[i] = outVal;
            else md[i-32] = outVal;
            step(1);
        end
        outWe = 1'b0;
        step(2);
        for (int k = 0; k < 200; k++) begin
            if (poll_ff.valid === 1'b1 && poll_ff.addr === 4'h0) break;
            step(1);
        end
        chk("outData", poll_ff.outData, md);
        posCmd = 1'b1;
        for (int i = 0; i < 32; i++) begin
            posChan = 9'(i);
            posVal = 1'($urandom);
            step(1);
            chk("posReject", posReject_ff, i < 8 || i > 17);
            if (i >= 8 && i <= 17) lo[i] = posVal;
        end
        posCmd = 1'b0;
        step(1);
        chk("localOut", localOut_ff, lo);
        done("outputs");
        wrap_up();
    end
endmodule

// ==== tb/can_io_module_model.sv ====
`timescale 1ns/1ps
module can_io_module_model import can_io_pkg::*; (
    input wire logic mclk, // Clock
    input poll_s poll, // Poll from controller
    input wire logic [15:0] fitted, // Modules on the net
    input wire logic [255:0] modIn, // Pins of all modules
    input wire logic [3:0] faultCode, // Code of faulty module
    input wire logic [3:0] faultAddr, // Faulty module
    input wire logic [3:0] lag, // Answer delay
    output rsp_s rsp // Answer
);
    logic [3:0] wait_ff;
    logic [3:0] who_ff;
    logic busy_ff;
    initial begin
        rsp = '0;
        busy_ff = 1'b0;
    end
    // ---------------------------------------------
    // Only a fitted module answers a poll to its address
    // ---------------------------------------------
    always @(posedge mclk) begin
        rsp.valid <= 1'b0;
        // Released data lines keep moving
        rsp.inputs <= ~rsp.inputs;
        if (poll.valid && fitted[poll.addr]) begin
            busy_ff <= 1'b1;
            who_ff <= poll.addr;
            wait_ff <= lag;
        end else if (busy_ff && wait_ff != 4'h0) begin
            wait_ff <= wait_ff - 4'h1;
        end else if (busy_ff) begin
            busy_ff <= 1'b0;
            rsp.valid <= 1'b1;
            rsp.addr <= {2'b00, who_ff};
            rsp.inputs <= modIn[who_ff*16 +: 16];
            rsp.fault <= (who_ff == faultAddr) ? faultCode : 4'h0;
        end
    end
endmodule
